// ==== dv/tft_autoset_cmd_init_bench.sv ====
// Bench joining both ends of the command bus.
`timescale 1ns/1ps
`default_nettype none
module tft_autoset_cmd_init_bench;
    localparam int         PCLK [8] = '{67, 69, 83, 87, 250, 260, 333, 347};
    localparam logic [7:0] R31 [4]  = '{8'he1, 8'hb1, 8'h31, 8'h21};
    localparam logic [7:0] SYS [8]  = '{8'h30, 8'h87, 8'h07, 8'h27, 8'h33, 8'hef, 8'h28, 8'h00};
    logic       ref_clk_i = 1'b0, rst_i = 1'b1, valid = 1'b0, is_c = 1'b0, tft = 1'b1, xtal = 1'b0;
    logic       rdy, waiting, error, mwr, auto, sfall, dstrong, c24, serr, usable, dual, err_seen = 1'b0;
    logic [7:0] byte_v = 8'h00, rdata, mdata, v;
    logic [6:0] reg_idx = 7'h00;
    logic [5:0] strap = 6'h00;
    logic [1:0] psize;
    logic [9:0] pclk;
    int         errors = 0, compares = 0, cycles = 0;
    host_cmd_if bus ();
    host_cmd_master #(.XTAL_WAIT(20)) host_cmd_master_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus),
        .valid_i(valid), .is_cmd_i(is_c), .byte_i(byte_v), .tft_panel_i(tft), .crystal_i(xtal),
        .ready_o(rdy), .waiting_o(waiting), .error_o(error));
    tft_cmd_device tft_cmd_device_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus), .config_strap_i(strap),
        .reg_idx_i(reg_idx), .reg_data_o(rdata), .mem_wr_o(mwr), .mem_data_o(mdata), .auto_mode_o(auto),
        .auto_usable_o(usable), .dual_panel_o(dual), .panel_size_o(psize), .shift_fall_o(sfall),
        .drive_strong_o(dstrong), .clk_24mhz_o(c24), .pclk_typ_o(pclk), .seq_error_o(serr));
    tft_autoset_cmd_init_checker tft_autoset_cmd_init_checker_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .wr(bus.wr), .is_cmd(bus.is_cmd), .data(bus.data), .mem_wr_o(mwr), .mem_data_o(mdata),
        .auto_mode_o(auto), .panel_size_o(psize), .shift_fall_o(sfall), .drive_strong_o(dstrong),
        .clk_24mhz_o(c24), .pclk_typ_o(pclk));
    // ==================================================================
    // Clock, refusal catcher and hang limit.
    always #2.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        err_seen <= err_seen | error;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // ==================================================================
    // Compares one value and counts it.
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds one request until the host end takes it.
    task automatic send(input logic c, input logic [7:0] b);
        @(negedge ref_clk_i);
        valid = 1'b1;
        is_c = c;
        byte_v = b;
        while (rdy !== 1'b1) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        valid = 1'b0;
    endtask
    // Reads one register two edges after presenting its index.
    task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
        @(negedge ref_clk_i);
        reg_idx = idx;
        repeat (2) @(negedge ref_clk_i);
        chk({2'b00, rdata}, {2'b00, exp});
    endtask
    // Resets the design with a new strap setting.
    task automatic boot(input logic [5:0] s);
        @(negedge ref_clk_i);
        rst_i = 1'b1;
        strap = s;
        repeat (8) @(negedge ref_clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==================================================================
    // Main sequence: every strap size and clock, then the command set.
    initial begin
        v = 8'($urandom(79));
        for (int k = 0; k < 8; k++) begin
            boot({k[0], 2'($urandom), 3'(k / 2 + 1)});
            chk(10'(psize), 10'(k / 2));
            chk(10'(sfall), 10'(!strap[3]));
            chk(10'(dstrong), 10'(strap[4]));
            chk(10'(c24), 10'(strap[5]));
            chk(pclk, 10'(PCLK[k]));
            chk(10'(usable), 10'h001);
            rd(7'h73, {8{strap[4]}});
            rd(7'h34, strap[3] ? 8'h35 : 8'h25);
            send(1'b1, tft_init_pkg::CMD_PLL_SETUP);
            send(1'b0, 8'($urandom));
            rd(7'h31, R31[k / 2] + 8'(strap[5]));
        end
        send(1'b1, tft_init_pkg::CMD_SYSTEM_SETUP);
        send(1'b0, 8'h08);
        repeat (3) @(negedge ref_clk_i);
        chk(10'(dual), 10'h001);
        chk(10'(usable), 10'h000);
        boot(6'h00);
        chk(10'(auto), 10'h000);
        xtal = 1'b1;
        send(1'b1, tft_init_pkg::CMD_SYSTEM_SETUP);
        repeat (2) @(negedge ref_clk_i);
        chk(10'(waiting), 10'h001);
        foreach (SYS[i]) send(1'b0, SYS[i]);
        rd(7'h04, 8'h33);
        send(1'b1, tft_init_pkg::CMD_PLL_SETUP);
        send(1'b0, 8'h21);
        tft = 1'b0;
        send(1'b1, tft_init_pkg::CMD_PLL_SETUP);
        send(1'b0, 8'h55);
        tft = 1'b1;
        rd(7'h31, 8'h21);
        send(1'b1, tft_init_pkg::CMD_PIXEL_HSCROLL);
        send(1'b0, 8'h00);
        send(1'b0, 8'($urandom) | 8'h01);
        rd(7'h1b, 8'h00);
        send(1'b1, tft_init_pkg::CMD_LAYER_COMBINE);
        send(1'b0, 8'h1c);
        rd(7'h18, 8'h1c);
        send(1'b1, tft_init_pkg::CMD_DISPLAY_ENABLE);
        send(1'b0, 8'h16);
        rd(7'h0a, 8'h16);
        send(1'b1, tft_init_pkg::CMD_CURSOR_SHAPE);
        send(1'b0, 8'h07);
        send(1'b0, 8'h87);
        rd(7'h15, 8'h07);
        rd(7'h16, 8'h87);
        send(1'b1, tft_init_pkg::CMD_TFT_SETUP_B);
        repeat (21) send(1'b0, 8'($urandom));
        send(1'b1, tft_init_pkg::CMD_SCROLL);
        v = 8'($urandom);
        send(1'b0, v);
        send(1'b0, 8'($urandom));
        send(1'b1, tft_init_pkg::CMD_SCROLL);
        send(1'b0, 8'h5a);
        rd(7'h4a, v);
        rd(7'h0b, 8'h5a);
        chk(10'(err_seen), 10'h001);
        chk(10'(serr), 10'h000);
        send(1'b1, tft_init_pkg::CMD_MEMORY_WRITE);
        repeat (4) send(1'b0, 8'($urandom));
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== dv/tft_autoset_cmd_init_checker.sv ====
// Checker for the host command bus and the strap-derived outputs.
`timescale 1ns/1ps
`default_nettype none
module tft_autoset_cmd_init_checker (
    input wire logic       ref_clk_i,      // System clock.
    input wire logic       rst_i,          // Reset.
    input wire logic       wr,             // Byte strobe.
    input wire logic       is_cmd,         // Command marker.
    input wire logic [7:0] data,           // Bus byte.
    input wire logic       mem_wr_o,       // Memory pulse.
    input wire logic [7:0] mem_data_o,     // Memory byte.
    input wire logic       auto_mode_o,    // Auto mode.
    input wire logic [1:0] panel_size_o,   // Panel size.
    input wire logic       shift_fall_o,   // Clock edge.
    input wire logic       drive_strong_o, // Pin drive.
    input wire logic       clk_24mhz_o,    // Clock strap.
    input wire logic [9:0] pclk_typ_o      // Pixel clock.
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] last_cmd;
    logic [4:0] pcnt;
    logic       mem_par;
    assign mem_par = wr && !is_cmd && last_cmd == tft_init_pkg::CMD_MEMORY_WRITE;
    // ==================================================================
    // Tracks the open command and its saturating parameter count.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || (wr && is_cmd)) begin
            pcnt <= 5'h00;
        end else if (wr && pcnt != 5'h1f) begin
            pcnt <= pcnt + 5'h01;
        end
    end
    // Remembers the last command byte on the bus.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            last_cmd <= 8'h00;
        end else if (wr && is_cmd) begin
            last_cmd <= data;
        end
    end
    // ==================================================================
    strobe_pulse_a: assert property (wr |=> !wr) else $error("strobe too long");
    mem_follow_a: assert property (mem_par |=> mem_wr_o && mem_data_o == $past(data))
        else $error("memory byte lost");
    mem_quiet_a: assert property (!mem_par |=> !mem_wr_o) else $error("stray memory byte");
    run_whole_a: assert property (wr && is_cmd && last_cmd == tft_init_pkg::CMD_TFT_SETUP_B |-> pcnt >= 5'd22)
        else $error("command cut into run");
    pclk_off_a: assert property (!auto_mode_o |-> pclk_typ_o == 10'd0) else $error("pclk not zero");
    vga_pclk_a: assert property (auto_mode_o && panel_size_o == 2'h2 && !clk_24mhz_o |-> pclk_typ_o == 10'd250)
        else $error("vga pclk wrong");
    wvga_pclk_a: assert property (auto_mode_o && panel_size_o == 2'h3 && !clk_24mhz_o |-> pclk_typ_o == 10'd333)
        else $error("wvga pclk wrong");
    shift_auto_a: assert property (shift_fall_o |-> auto_mode_o) else $error("edge outside auto");
    drive_auto_a: assert property (drive_strong_o |-> auto_mode_o) else $error("drive outside auto");
    cover property (wr && is_cmd && data == tft_init_pkg::CMD_TFT_SETUP_B);
    cover property (mem_wr_o);
    cover property (auto_mode_o && clk_24mhz_o);
endmodule
`default_nettype wire

// ==== logic/host_cmd_if.sv ====
// Host command bus between the host end and the controller end.
`timescale 1ns/1ps
`default_nettype none
interface host_cmd_if;
    logic       wr;      // One-cycle byte strobe.
    logic       is_cmd;  // High for a command byte, low for a parameter.
    logic [7:0] data;    // Byte on the bus.

    modport host   (output wr, output is_cmd, output data);
    modport device (input wr, input is_cmd, input data);
endinterface
`default_nettype wire

// ==== logic/host_cmd_master.sv ====
// Host end: issues command and parameter bytes with the start-up pacing.
`timescale 1ns/1ps
`default_nettype none
module host_cmd_master #(
    parameter int XTAL_WAIT = tft_init_pkg::XTAL_WAIT_CYC
) (
    input  wire logic       ref_clk_i,   // System clock.
    input  wire logic       rst_i,       // Synchronous reset, active high.
    host_cmd_if.host        bus,         // Command bus to the controller.
    input  wire logic       valid_i,     // Byte request.
    input  wire logic       is_cmd_i,    // Request is a command byte.
    input  wire logic [7:0] byte_i,      // Request byte.
    input  wire logic       tft_panel_i, // A TFT panel is fitted.
    input  wire logic       crystal_i,   // Clock comes from a crystal.
    output logic            ready_o,     // Request may be taken.
    output logic            waiting_o,   // Crystal wait in progress.
    output logic            error_o      // Pulse: command refused.
);
    typedef enum {IDLE, SEND, WAIT} host_state_t;

    host_state_t state;
    logic        dropping;
    logic [7:0]  tft_b_count;
    logic        tft_b_open;
    logic [31:0] wait_count;
    logic        tft_only;
    logic        early_cmd;

    // TFT-only commands, and a command cut into an open 64h sequence.
    assign tft_only  = byte_i == tft_init_pkg::CMD_PLL_SETUP || byte_i == tft_init_pkg::CMD_TFT_SETUP_A
                    || byte_i == tft_init_pkg::CMD_TFT_SETUP_B;
    assign early_cmd = is_cmd_i && tft_b_open && tft_b_count != tft_init_pkg::LEN_TFT_SETUP_B;
    assign ready_o   = state == IDLE;
    assign waiting_o = state == WAIT;

    // Request handling, pacing and crystal wait.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state      <= IDLE;
            bus.wr     <= 1'b0;
            bus.is_cmd <= 1'b0;
            bus.data   <= 8'h00;
            dropping   <= 1'b0;
            wait_count <= 32'h0;
            error_o    <= 1'b0;
        end else begin
            bus.wr  <= 1'b0;
            error_o <= 1'b0;
            case (state)
                IDLE: begin
                    if (valid_i) begin
                        if (early_cmd) begin
                            error_o <= 1'b1;
                        end else if (is_cmd_i && tft_only && !tft_panel_i) begin
                            dropping <= 1'b1;
                        end else if (!is_cmd_i && dropping) begin
                            dropping <= 1'b1;
                        end else begin
                            dropping   <= is_cmd_i ? 1'b0 : dropping;
                            bus.wr     <= 1'b1;
                            bus.is_cmd <= is_cmd_i;
                            bus.data   <= byte_i;
                            if (is_cmd_i && byte_i == tft_init_pkg::CMD_SYSTEM_SETUP && crystal_i) begin
                                state      <= WAIT;
                                wait_count <= 32'(XTAL_WAIT);
                            end else begin
                                state <= SEND;
                            end
                        end
                    end
                end
                SEND: begin
                    state <= IDLE;
                end
                WAIT: begin
                    wait_count <= wait_count - 32'h1;
                    if (wait_count <= 32'h1) begin
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // Parameter count after a 64h command.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tft_b_open  <= 1'b0;
            tft_b_count <= 8'h00;
        end else if (bus.wr && bus.is_cmd) begin
            tft_b_open  <= bus.data == tft_init_pkg::CMD_TFT_SETUP_B;
            tft_b_count <= 8'h00;
        end else if (bus.wr && tft_b_count != tft_init_pkg::LEN_TFT_SETUP_B) begin
            tft_b_count <= tft_b_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== logic/tft_cmd_device.sv ====
// Controller end: strap-driven automatic TFT setup and host command decoding.
`timescale 1ns/1ps
`default_nettype none
module tft_cmd_device (
    input  wire logic       ref_clk_i,     // System clock.
    input  wire logic       rst_i,         // Synchronous reset, active high.
    host_cmd_if.device      bus,           // Command bus from the host.
    input  wire logic [5:0] config_strap_i, // Strap pins 10..5.
    input  wire logic [6:0] reg_idx_i,     // Register read index.
    output logic      [7:0] reg_data_o,    // Register read value.
    output logic            mem_wr_o,      // Pulse: display memory byte.
    output logic      [7:0] mem_data_o,    // Display memory byte.
    output logic            auto_mode_o,   // Automatic setting mode on.
    output logic            auto_usable_o, // Auto mode with single panel.
    output logic            dual_panel_o,  // System register bit 3.
    output logic      [1:0] panel_size_o,  // 0 QVGA .. 3 WVGA.
    output logic            shift_fall_o,  // Pixel clock falling-edge data.
    output logic            drive_strong_o, // Strong TFT pin drive.
    output logic            clk_24mhz_o,   // Input clock is 24 MHz.
    output logic      [9:0] pclk_typ_o,    // Pixel clock, 100 kHz units.
    output logic            seq_error_o    // Command cut into 64h run.
);
    // ==========================================================================
    // Strap capture.
    // ==========================================================================
    logic [5:0] strap_meta;
    logic [5:0] strap_sync;
    logic [5:0] strap;
    logic       strap_taken;
    logic       auto_mode;

    // Two-stage synchroniser for the strap pins.
    always_ff @(posedge ref_clk_i) begin
        strap_meta <= config_strap_i;
        strap_sync <= strap_meta;
    end

    // Straps are latched once, on the first edge after reset release.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            strap_taken <= 1'b0;
            strap       <= 6'h00;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            strap       <= strap_sync;
        end
    end

    // Size codes 001..100 enable the automatic mode.
    assign auto_mode = strap[2:0] >= 3'h1 && strap[2:0] <= 3'h4;

    // ==========================================================================
    // Command decoding.
    // ==========================================================================
    logic [7:0] cmd;
    logic [7:0] pcount;
    logic [7:0] plen;
    logic [6:0] pbase;
    logic       wr_cmd;
    logic       wr_par;
    logic       early;
    logic [6:0] widx;
    logic       wr_reg;

    assign early  = cmd == tft_init_pkg::CMD_TFT_SETUP_B && pcount < tft_init_pkg::LEN_TFT_SETUP_B;
    assign wr_cmd = bus.wr && bus.is_cmd && !early;
    assign wr_par = bus.wr && !bus.is_cmd;

    // Parameter count and register base of the current command.
    always_comb begin
        plen  = 8'h00;
        pbase = tft_init_pkg::BASE_SYSTEM_SETUP;
        case (cmd)
            tft_init_pkg::CMD_SYSTEM_SETUP: begin
                plen  = tft_init_pkg::LEN_SYSTEM_SETUP;
                pbase = tft_init_pkg::BASE_SYSTEM_SETUP;
            end
            tft_init_pkg::CMD_SCROLL: begin
                plen  = tft_init_pkg::LEN_SCROLL;
                pbase = tft_init_pkg::BASE_SCROLL;
            end
            tft_init_pkg::CMD_DISPLAY_ENABLE: begin
                plen  = tft_init_pkg::LEN_ONE;
                pbase = tft_init_pkg::BASE_DISPLAY_ATTR;
            end
            tft_init_pkg::CMD_PIXEL_HSCROLL: begin
                plen  = tft_init_pkg::LEN_ONE;
                pbase = tft_init_pkg::BASE_PIXEL_HSCROLL;
            end
            tft_init_pkg::CMD_LAYER_COMBINE: begin
                plen  = tft_init_pkg::LEN_ONE;
                pbase = tft_init_pkg::BASE_LAYER_COMBINE;
            end
            tft_init_pkg::CMD_CURSOR_SHAPE: begin
                plen  = tft_init_pkg::LEN_CURSOR_SHAPE;
                pbase = tft_init_pkg::BASE_CURSOR_SHAPE;
            end
            tft_init_pkg::CMD_PLL_SETUP: begin
                plen  = tft_init_pkg::LEN_PLL_SETUP;
                pbase = tft_init_pkg::BASE_PLL_SETUP;
            end
            tft_init_pkg::CMD_TFT_SETUP_A: begin
                plen  = tft_init_pkg::LEN_ONE;
                pbase = tft_init_pkg::BASE_TFT_SETUP_A;
            end
            tft_init_pkg::CMD_TFT_SETUP_B: begin
                plen  = tft_init_pkg::LEN_TFT_SETUP_B;
                pbase = tft_init_pkg::BASE_TFT_SETUP_B;
            end
            default: begin
                plen  = 8'h00;
                pbase = tft_init_pkg::BASE_SYSTEM_SETUP;
            end
        endcase
    end

    // Target register of a parameter; writes to the TFT group are dropped in auto mode.
    assign widx   = 7'(pbase + pcount[6:0]);
    assign wr_reg = wr_par && pcount < plen
                 && !(auto_mode && widx >= tft_init_pkg::REG_PROT_FIRST
                      && widx <= tft_init_pkg::REG_PROT_LAST);

    // Current command and count of parameters since it.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmd    <= 8'h00;
            pcount <= 8'h00;
        end else if (wr_cmd) begin
            cmd    <= bus.data;
            pcount <= 8'h00;
        end else if (wr_par && pcount != 8'hff) begin
            pcount <= pcount + 8'h01;
        end
    end

    // Sticky flag for a command refused inside a 64h run; set beats clear.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            seq_error_o <= 1'b0;
        end else if (bus.wr && bus.is_cmd && early) begin
            seq_error_o <= 1'b1;
        end else if (wr_cmd && bus.data == tft_init_pkg::CMD_TFT_SETUP_B) begin
            seq_error_o <= 1'b0;
        end
    end

    // Parameters of a memory write go to display memory.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mem_wr_o   <= 1'b0;
            mem_data_o <= 8'h00;
        end else begin
            mem_wr_o <= wr_par && cmd == tft_init_pkg::CMD_MEMORY_WRITE;
            if (wr_par) begin
                mem_data_o <= bus.data;
            end
        end
    end

    // ==========================================================================
    // Register file.
    // ==========================================================================
    logic [7:0] regs [tft_init_pkg::REG_COUNT];

    // Plain storage with the predecessor layout.
    generate
        for (genvar i = 0; i < tft_init_pkg::REG_COUNT; i++) begin : g_reg
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    regs[i] <= tft_init_pkg::RESET_VALUE;
                end else if (wr_reg && widx == 7'(i)) begin
                    regs[i] <= bus.data;
                end
            end
        end
    endgenerate

    // Strap-derived value for the protected group.
    function automatic logic [7:0] auto_value(input logic [6:0] idx, input logic [5:0] s);
        logic [31:0] row;
        logic [1:0]  sz;
        logic [7:0]  v;
        sz  = 2'(s[2:0] - 3'h1);
        row = 32'h0;
        v   = 8'h00;
        if (idx <= tft_init_pkg::REG_AUTO_LAST) begin
            row = tft_init_pkg::AUTO_TABLE[5'(idx - tft_init_pkg::REG_PROT_FIRST)];
            v   = row[8*sz +: 8];
        end
        if (idx == tft_init_pkg::REG_PROT_FIRST) begin
            v = v + {7'h00, s[tft_init_pkg::STRAP_CLK_BIT]};
        end else if (idx == tft_init_pkg::REG_PLL_N && s[tft_init_pkg::STRAP_CLK_BIT]) begin
            v = tft_init_pkg::PLL_N_24MHZ;
        end else if (idx == tft_init_pkg::BASE_TFT_SETUP_A && s[tft_init_pkg::STRAP_POL_BIT]) begin
            v = tft_init_pkg::TFT_A_RISING;
        end else if (idx == tft_init_pkg::REG_DRIVE) begin
            v = s[tft_init_pkg::STRAP_DRV_BIT] ? tft_init_pkg::DRIVE_STRONG
                                               : tft_init_pkg::DRIVE_NORMAL;
        end
        return v;
    endfunction

    // Read port: the protected group shows strap values in auto mode.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_data_o <= 8'h00;
        end else if (auto_mode && reg_idx_i >= tft_init_pkg::REG_PROT_FIRST
                     && reg_idx_i <= tft_init_pkg::REG_PROT_LAST) begin
            reg_data_o <= auto_value(reg_idx_i, strap);
        end else begin
            reg_data_o <= regs[reg_idx_i];
        end
    end

    // ==========================================================================
    // Mode outputs.
    // ==========================================================================
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            auto_mode_o    <= 1'b0;
            auto_usable_o  <= 1'b0;
            dual_panel_o   <= 1'b0;
            panel_size_o   <= 2'h0;
            shift_fall_o   <= 1'b0;
            drive_strong_o <= 1'b0;
            clk_24mhz_o    <= 1'b0;
            pclk_typ_o     <= 10'h000;
        end else begin
            auto_mode_o    <= auto_mode;
            dual_panel_o   <= regs[tft_init_pkg::BASE_SYSTEM_SETUP][tft_init_pkg::DUAL_PANEL_BIT];
            auto_usable_o  <= auto_mode
                && !regs[tft_init_pkg::BASE_SYSTEM_SETUP][tft_init_pkg::DUAL_PANEL_BIT];
            panel_size_o   <= 2'(strap[2:0] - 3'h1);
            shift_fall_o   <= auto_mode && !strap[tft_init_pkg::STRAP_POL_BIT];
            drive_strong_o <= auto_mode && strap[tft_init_pkg::STRAP_DRV_BIT];
            clk_24mhz_o    <= strap[tft_init_pkg::STRAP_CLK_BIT];
            pclk_typ_o     <= auto_mode
                ? tft_init_pkg::PCLK_TYP[2'(strap[2:0] - 3'h1)][!strap[tft_init_pkg::STRAP_CLK_BIT]]
                : 10'h000;
        end
    end
endmodule
`default_nettype wire

// ==== logic/tft_init_pkg.sv ====
// Shared constants for the start-up configuration path and its host command bus.
package tft_init_pkg;

    // ==========================================================================
    // Command codes.
    // ==========================================================================
    localparam logic [7:0] CMD_SYSTEM_SETUP   = 8'h40;
    localparam logic [7:0] CMD_MEMORY_WRITE   = 8'h42;
    localparam logic [7:0] CMD_SCROLL         = 8'h44;
    localparam logic [7:0] CMD_DISPLAY_ENABLE = 8'h59;
    localparam logic [7:0] CMD_PIXEL_HSCROLL  = 8'h5a;
    localparam logic [7:0] CMD_LAYER_COMBINE  = 8'h5b;
    localparam logic [7:0] CMD_CURSOR_SHAPE   = 8'h5d;
    localparam logic [7:0] CMD_PLL_SETUP      = 8'h62;
    localparam logic [7:0] CMD_TFT_SETUP_A    = 8'h63;
    localparam logic [7:0] CMD_TFT_SETUP_B    = 8'h64;

    // ==========================================================================
    // Parameter counts and first register index of each command except memory write.
    // ==========================================================================
    localparam logic [7:0] LEN_SYSTEM_SETUP   = 8'h08;
    localparam logic [7:0] LEN_SCROLL         = 8'h0a;
    localparam logic [7:0] LEN_ONE            = 8'h01;
    localparam logic [7:0] LEN_CURSOR_SHAPE   = 8'h02;
    localparam logic [7:0] LEN_PLL_SETUP      = 8'h03;
    localparam logic [7:0] LEN_TFT_SETUP_B    = 8'h16;
    localparam logic [6:0] BASE_SYSTEM_SETUP  = 7'h00;
    localparam logic [6:0] BASE_SCROLL        = 7'h0b;
    localparam logic [6:0] BASE_DISPLAY_ATTR  = 7'h0a;
    localparam logic [6:0] BASE_CURSOR_SHAPE  = 7'h15;
    localparam logic [6:0] BASE_LAYER_COMBINE = 7'h18;
    localparam logic [6:0] BASE_PIXEL_HSCROLL = 7'h1b;
    localparam logic [6:0] BASE_PLL_SETUP     = 7'h31;
    localparam logic [6:0] BASE_TFT_SETUP_A   = 7'h34;
    localparam logic [6:0] BASE_TFT_SETUP_B   = 7'h35;

    // ==========================================================================
    // Register file layout.
    // ==========================================================================
    localparam int         REG_COUNT          = 128;
    localparam logic [6:0] REG_PROT_FIRST     = 7'h31;
    localparam logic [6:0] REG_PROT_LAST      = 7'h73;
    localparam logic [6:0] REG_AUTO_LAST      = 7'h4a;
    localparam logic [6:0] REG_DRIVE          = 7'h73;
    localparam logic [6:0] REG_PLL_N          = 7'h32;
    localparam int         DUAL_PANEL_BIT     = 3;
    localparam logic [7:0] RESET_VALUE        = 8'h00;

    // ==========================================================================
    // Strap field positions within config_strap[10:5], held as bits 5:0.
    // ==========================================================================
    localparam int STRAP_SIZE_LSB = 0;
    localparam int STRAP_POL_BIT  = 3;
    localparam int STRAP_DRV_BIT  = 4;
    localparam int STRAP_CLK_BIT  = 5;

    // ==========================================================================
    // Automatic values for registers 31h..4Ah, bytes for WVGA,VGA,WQVGA,QVGA.
    // ==========================================================================
    localparam logic [31:0] AUTO_TABLE [26] = '{
        32'h2131b1e1, 32'h99999999, 32'h24242424, 32'h25252525,
        32'h1f1f0f97, 32'h04030201, 32'h1f7fdf3f, 32'h03020101,
        32'h2e902846, 32'h00000000, 32'h0f0f1f07, 32'h02020101,
        32'hdfdf0fef, 32'h01010100, 32'h1723080d, 32'h00000000,
        32'h02020202, 32'h07070707, 32'h00000000, 32'h00000000,
        32'h9900aa00, 32'h01020204, 32'h00008700, 32'h02020304,
        32'h00000000, 32'h00000000};
    localparam logic [7:0] PLL_N_24MHZ     = 8'h9c;
    localparam logic [7:0] TFT_A_RISING    = 8'h35;
    localparam logic [7:0] DRIVE_STRONG    = 8'hff;
    localparam logic [7:0] DRIVE_NORMAL    = 8'h00;

    // Typical pixel clock in 100 kHz units: {24 MHz, 20 MHz} per panel size.
    localparam logic [9:0] PCLK_TYP [4][2] = '{
        '{10'd69, 10'd67}, '{10'd87, 10'd83},
        '{10'd260, 10'd250}, '{10'd347, 10'd333}};

    // ==========================================================================
    // Host timing.
    // ==========================================================================
    localparam int CLK_MHZ        = 200;
    localparam int XTAL_WAIT_US   = 1000;
    localparam int XTAL_WAIT_CYC  = XTAL_WAIT_US * CLK_MHZ;

endpackage
